// ---- pkg/lta_pkg.sv ----
/*
 * lta_pkg: constants, codes and state type for the line-side activation
 * state machine (final activation states and their budgets).
 * Assumes a 20 MHz system clock; all event inputs are one-cycle pulses.
 */
`default_nettype none
package lta_pkg;
	// ------------------------------------------------------------
	// clock and start-up budgets
	// ------------------------------------------------------------
	localparam int unsigned LTA_CLK_HZ = 20_000_000;
	localparam int unsigned LTA_CYC_PER_MS = LTA_CLK_HZ / 1000;
	localparam int unsigned LTA_NORMAL_MS = 100;
	localparam int unsigned LTA_WORST_MS = 150;
	localparam int unsigned LTA_NORMAL_CYC = LTA_NORMAL_MS * LTA_CYC_PER_MS;
	localparam int unsigned LTA_WORST_CYC = LTA_WORST_MS * LTA_CYC_PER_MS;
	localparam int LTA_TMR_W = 22;

	// ------------------------------------------------------------
	// function element codes reported to the exchange side
	// ------------------------------------------------------------
	localparam logic [3:0] LTA_FE_NONE = 4'h0;
	localparam logic [3:0] LTA_FE_ACTIVATING = 4'h2;
	localparam logic [3:0] LTA_FE_ACTIVATED = 4'h3;
	localparam logic [3:0] LTA_FE_LOOP_ACTIVE = 4'h4;
	localparam logic [3:0] LTA_FE_INITIATED = 4'h6;
	localparam logic [3:0] LTA_FE_FAULT = 4'h7;
	localparam logic [3:0] LTA_FE_LOOP_DEFECT = 4'hc;

	// ------------------------------------------------------------
	// line signal codes sent to the remote terminator
	// ------------------------------------------------------------
	localparam logic [3:0] LTA_LSIG_NONE = 4'h0;
	localparam logic [3:0] LTA_LSIG_TRAINING = 4'h4;
	localparam logic [3:0] LTA_LSIG_LOOP_OPERATION = 4'h9;

	// ------------------------------------------------------------
	// states, gray coded in order from deactivated through malfunction; the pending states are outside that sequence
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		LTA_DEACT = 4'h0,
		LTA_INITIATED = 4'h1,
		LTA_ACTIVATING = 4'h3,
		LTA_ACTIVATED = 4'h2,
		LTA_LOOP_ACTIVE = 4'h6,
		LTA_LOOP_DEFECT = 4'h7,
		LTA_FRAME_LOSS = 4'h5,
		LTA_MALFUNCTION = 4'h4,
		LTA_PEND_A = 4'hc,
		LTA_PEND_B = 4'hd
	} lta_state_t;
endpackage
`default_nettype wire

// ---- pkg/lta_tmr_if.sv ----
/*
 * lta_tmr_if: link between the state machine and its start-up budget timer.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface lta_tmr_if;
	logic run;
	logic restart;
	logic ext_expiry;
	logic normal_over;
	logic worst_over;
	modport fsm (output run, output restart, output ext_expiry,
		input normal_over, input worst_over);
	modport tmr (input run, input restart, input ext_expiry,
		output normal_over, output worst_over);
endinterface
`default_nettype wire

// ---- core/lta_budget_timer.sv ----
/*
 * lta_budget_timer: counts the line-side start-up and reframing budget
 * and pulses when the normal and worst-case limits are reached.
 * Assumes restart is a one-cycle pulse on entry to a start-up phase.
 */
`timescale 1ns/1ns
`default_nettype none
module lta_budget_timer
	import lta_pkg::*;
#(
	parameter logic [LTA_TMR_W-1:0] NORMAL_CYCLES = LTA_TMR_W'(LTA_NORMAL_CYC),
	parameter logic [LTA_TMR_W-1:0] WORST_CYCLES = LTA_TMR_W'(LTA_WORST_CYC)
)
(
	input wire logic sys_clk, // system clock
	input wire logic rst, // async reset, active high
	lta_tmr_if.tmr tif // control from the state machine
);
	logic [LTA_TMR_W-1:0] cnt;
	logic running;

	// ------------------------------------------------------------
	// counter, halts at the worst-case limit
	// ------------------------------------------------------------
	assign running = tif.run && !tif.restart;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cnt <= '0;
		else if (tif.restart)
			cnt <= '0;
		else if (running && cnt != WORST_CYCLES)
			cnt <= cnt + 1'b1;
	end

	// ------------------------------------------------------------
	// expiry pulses; an external expiry stands in for the worst case
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tif.normal_over <= 1'b0;
			tif.worst_over <= 1'b0;
		end
		else
		begin
			tif.normal_over <= running && cnt == NORMAL_CYCLES - 1'b1;
			tif.worst_over <= running &&
				(cnt == WORST_CYCLES - 1'b1 || tif.ext_expiry);
		end
	end
endmodule // lta_budget_timer
`default_nettype wire

// ---- core/lta_fsm.sv ----
/*
 * lta_fsm: line-side activation state machine, final states: activated,
 * loopback, loopback defect, lost framing and malfunction, with the
 * start-up budget monitor.
 * Assumes every event input is a one-cycle pulse from logic on sys_clk.
 */
// Notes on behaviour
// - loopback active plus loopback activating signal enters defect, reports it
// - defect state returns to loopback active on loopback operation signal
// - framing loss enters lost-framing, sends training and fault indication
// - lost-framing moves to activated when receiver resynchronizes
// - lost-framing acts like activating except for its reported element
// - remote signal loss enters malfunction from every other active state
// - malfunction moves to activating when remote operating signal returns
// - impossible or unlisted events leave state and outputs unchanged
// - received-signal loss moves loopback states to lost-framing; may merge
// - remote training detection counts as remote-to-line synchronization
// - timer expiry may come from an external element instead
// - remote signal return picks pending state from last request order
// - start-up must finish within normal and worst-case limits
// - line side budget is 100 ms normal and 150 ms worst case
// - the same limits bound reframing after framing loss
`timescale 1ns/1ns
`default_nettype none
module lta_fsm
	import lta_pkg::*;
#(
	parameter logic [LTA_TMR_W-1:0] NORMAL_CYCLES = LTA_TMR_W'(LTA_NORMAL_CYC),
	parameter logic [LTA_TMR_W-1:0] WORST_CYCLES = LTA_TMR_W'(LTA_WORST_CYC),
	parameter bit LOS_AS_FRAME_LOSS = 1'b0
)
(
	input wire logic sys_clk, // system clock, 20 MHz
	input wire logic rst, // async reset, active high
	input wire logic ev_activate_req, // activate request pulse
	input wire logic ev_deactivate_req, // deactivate request pulse
	input wire logic ev_remote_op, // remote operating signal appeared
	input wire logic ev_remote_lost, // remote operating signal gone
	input wire logic ev_remote_train, // remote training signal detected
	input wire logic ev_rx_synced, // receiver synchronized, remote to line
	input wire logic ev_frame_loss, // receiver lost frame alignment
	input wire logic ev_rx_loss, // loss of received signal
	input wire logic ev_loop_activating, // loopback activating signal
	input wire logic ev_loop_operation, // loopback operation signal
	input wire logic ev_timer_expiry, // external budget expiry
	output logic [3:0] function_element, // element reported to exchange
	output logic function_element_stb, // pulse on each new element
	output logic tx_frame_on, // frame-bearing signal sent
	output logic [3:0] tx_line_signal, // code of signal sent to remote
	output logic startup_late, // normal budget exceeded
	output logic startup_fail, // worst-case budget exceeded
	output logic [3:0] state_code // current state
);
	lta_state_t state;
	lta_state_t next_state;
	logic act_after_deact;
	logic frame_loss_ev;
	logic rx_loss_ev;
	logic synced_ev;
	logic in_startup;
	logic next_in_startup;
	logic restart;
	lta_tmr_if tif();

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// event qualification
	// ------------------------------------------------------------
	assign rx_loss_ev = ev_rx_loss && !LOS_AS_FRAME_LOSS;
	assign frame_loss_ev = ev_frame_loss || (ev_rx_loss && LOS_AS_FRAME_LOSS);
	assign synced_ev = ev_rx_synced || ev_remote_train;

	// ------------------------------------------------------------
	// request order memory for the pending choice
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			act_after_deact <= 1'b0;
		else if (ev_activate_req)
			act_after_deact <= 1'b1;
		else if (ev_deactivate_req)
			act_after_deact <= 1'b0;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		if (ev_deactivate_req)
			next_state = LTA_DEACT;
		else
		begin
			case (state)
			LTA_DEACT:
				if (ev_remote_op)
					next_state = act_after_deact ? LTA_PEND_A : LTA_PEND_B;
			LTA_PEND_A, LTA_PEND_B:
				if (ev_activate_req)
					next_state = LTA_INITIATED;
			LTA_INITIATED:
				if (ev_remote_lost)
					next_state = LTA_MALFUNCTION;
				else if (ev_remote_op)
					next_state = LTA_ACTIVATING;
			LTA_ACTIVATING, LTA_FRAME_LOSS:
				if (ev_remote_lost)
					next_state = LTA_MALFUNCTION;
				else if (synced_ev)
					next_state = LTA_ACTIVATED;
			LTA_ACTIVATED:
				if (ev_remote_lost)
					next_state = LTA_MALFUNCTION;
				else if (frame_loss_ev || rx_loss_ev)
					next_state = LTA_FRAME_LOSS;
				else if (ev_loop_operation)
					next_state = LTA_LOOP_ACTIVE;
			LTA_LOOP_ACTIVE:
				if (ev_remote_lost)
					next_state = LTA_MALFUNCTION;
				else if (frame_loss_ev || rx_loss_ev)
					next_state = LTA_FRAME_LOSS;
				else if (ev_loop_activating)
					next_state = LTA_LOOP_DEFECT;
			LTA_LOOP_DEFECT:
				if (ev_remote_lost)
					next_state = LTA_MALFUNCTION;
				else if (frame_loss_ev || rx_loss_ev)
					next_state = LTA_FRAME_LOSS;
				else if (ev_loop_operation)
					next_state = LTA_LOOP_ACTIVE;
			LTA_MALFUNCTION:
				if (ev_remote_op)
					next_state = LTA_ACTIVATING;
			default:
				next_state = LTA_DEACT;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state <= LTA_DEACT;
		else
			state <= next_state;
	end

	// ------------------------------------------------------------
	// reports toward the exchange side, one per state entry
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			function_element <= LTA_FE_NONE;
			function_element_stb <= 1'b0;
		end
		else
		begin
			function_element_stb <= next_state != state;
			case (next_state)
			LTA_INITIATED: function_element <= LTA_FE_INITIATED;
			LTA_ACTIVATING: function_element <= LTA_FE_ACTIVATING;
			LTA_ACTIVATED: function_element <= LTA_FE_ACTIVATED;
			LTA_LOOP_ACTIVE: function_element <= LTA_FE_LOOP_ACTIVE;
			LTA_LOOP_DEFECT: function_element <= LTA_FE_LOOP_DEFECT;
			LTA_FRAME_LOSS: function_element <= LTA_FE_FAULT;
			LTA_MALFUNCTION: function_element <= LTA_FE_FAULT;
			default: function_element <= LTA_FE_NONE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// signals toward the remote terminator
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_frame_on <= 1'b0;
			tx_line_signal <= LTA_LSIG_NONE;
		end
		else
		begin
			case (next_state)
			LTA_ACTIVATED, LTA_LOOP_ACTIVE, LTA_LOOP_DEFECT:
			begin
				tx_frame_on <= 1'b1;
				tx_line_signal <= LTA_LSIG_LOOP_OPERATION;
			end
			LTA_INITIATED, LTA_ACTIVATING, LTA_FRAME_LOSS, LTA_MALFUNCTION:
			begin
				tx_frame_on <= 1'b1;
				tx_line_signal <= LTA_LSIG_TRAINING;
			end
			default:
			begin
				tx_frame_on <= 1'b0;
				tx_line_signal <= LTA_LSIG_NONE;
			end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state_code <= LTA_DEACT;
		else
			state_code <= next_state;
	end

	// ------------------------------------------------------------
	// start-up and reframing budget
	// ------------------------------------------------------------
	// the budget restarts on each fresh start-up and on every framing loss,
	// so a slow reframe is judged on its own and not on the earlier start-up
	assign next_in_startup = next_state == LTA_INITIATED ||
		next_state == LTA_ACTIVATING || next_state == LTA_FRAME_LOSS;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			in_startup <= 1'b0;
			restart <= 1'b0;
		end
		else
		begin
			in_startup <= next_in_startup;
			restart <= (next_in_startup && !in_startup) ||
				(next_state == LTA_FRAME_LOSS && state != LTA_FRAME_LOSS);
		end
	end

	assign tif.run = in_startup;
	assign tif.restart = restart;
	assign tif.ext_expiry = ev_timer_expiry;

	lta_budget_timer #(
		.NORMAL_CYCLES(NORMAL_CYCLES),
		.WORST_CYCLES(WORST_CYCLES)
	) u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.tif(tif)
	);

	// set wins over the restart that would clear it
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			startup_late <= 1'b0;
			startup_fail <= 1'b0;
		end
		else
		begin
			if (tif.normal_over)
				startup_late <= 1'b1;
			else if (restart)
				startup_late <= 1'b0;
			if (tif.worst_over)
				startup_fail <= 1'b1;
			else if (restart)
				startup_fail <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_defect_entry: assert property (
		state == LTA_LOOP_ACTIVE && ev_loop_activating && !ev_deactivate_req
		&& !ev_remote_lost && !ev_frame_loss && !ev_rx_loss
		|=> state == LTA_LOOP_DEFECT && function_element == LTA_FE_LOOP_DEFECT
		&& function_element_stb)
		else $error("loopback defect not entered");
	a_defect_exit: assert property (
		state == LTA_LOOP_DEFECT && ev_loop_operation && !ev_deactivate_req
		&& !ev_remote_lost && !ev_frame_loss && !ev_rx_loss
		|=> state == LTA_LOOP_ACTIVE)
		else $error("defect state did not return to loopback");
	a_frame_loss: assert property (
		(state == LTA_ACTIVATED || state == LTA_LOOP_ACTIVE) && ev_frame_loss
		&& !ev_deactivate_req && !ev_remote_lost
		|=> state == LTA_FRAME_LOSS && tx_line_signal == LTA_LSIG_TRAINING
		&& function_element == LTA_FE_FAULT)
		else $error("lost framing not entered");
	a_reframe: assert property (
		state == LTA_FRAME_LOSS && ev_rx_synced && !ev_deactivate_req
		&& !ev_remote_lost |=> state == LTA_ACTIVATED)
		else $error("reframe did not reach activated");
	a_train_sync: assert property (
		state == LTA_ACTIVATING && ev_remote_train && !ev_deactivate_req
		&& !ev_remote_lost |=> state == LTA_ACTIVATED)
		else $error("remote training not taken as sync");
	a_malf_entry: assert property (
		state != LTA_MALFUNCTION && state != LTA_DEACT && state != LTA_PEND_A
		&& state != LTA_PEND_B && ev_remote_lost && !ev_deactivate_req
		|=> state == LTA_MALFUNCTION && tx_frame_on
		&& function_element == LTA_FE_FAULT)
		else $error("malfunction not entered");
	a_malf_exit: assert property (
		state == LTA_MALFUNCTION && ev_remote_op && !ev_deactivate_req
		|=> state == LTA_ACTIVATING ##1 state == LTA_ACTIVATING
		|| $past(ev_deactivate_req) || $past(ev_remote_lost)
		|| $past(synced_ev))
		else $error("malfunction did not go to activating");
	a_hold_quiet: assert property (
		next_state == state |=> !function_element_stb
		&& $stable(function_element) && $stable(tx_line_signal))
		else $error("output moved without a state change");
	a_deact_all: assert property (
		ev_deactivate_req |=> state == LTA_DEACT && !tx_frame_on)
		else $error("deactivate request not obeyed");
	a_pending_pick: assert property (
		state == LTA_DEACT && ev_remote_op && !ev_deactivate_req
		|=> state == ($past(act_after_deact) ? LTA_PEND_A : LTA_PEND_B))
		else $error("wrong pending state chosen");
	a_loop_signal: assert property (
		state inside {LTA_ACTIVATED, LTA_LOOP_ACTIVE, LTA_LOOP_DEFECT}
		|-> tx_frame_on && tx_line_signal == LTA_LSIG_LOOP_OPERATION)
		else $error("loop states not sending loop operation");
	a_budget_fail: assert property (
		tif.worst_over |=> startup_fail [*2] or
		(startup_fail ##1 restart))
		else $error("worst-case expiry not flagged");
endmodule // lta_fsm
`default_nettype wire

// ---- verif/lta_far_end.sv ----
/*
 * lta_far_end: far-side model standing for the exchange side and the
 * remote terminator; forwards event pulses asked by the bench and can
 * answer the training signal by itself after a chosen delay.
 * Assumes the bench changes its commands at the falling clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module lta_far_end
	import lta_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic [10:0] cmd, // event pulses asked by the bench
	input wire logic auto_train, // answer training without the bench
	input wire logic [7:0] train_delay, // cycles before answering
	input wire logic [3:0] tx_line_signal, // signal from the line side
	output logic [10:0] ev // events toward the line side
);
	logic [7:0] wait_cnt = 8'h00;
	logic train_pulse = 1'b0;
	logic answered = 1'b0;

	// ------------------------------------------------------------
	// remote training answer
	// ------------------------------------------------------------
	// one answer per training burst; a real terminator does not repeat
	always @(negedge sys_clk)
	begin
		train_pulse <= 1'b0;
		if (!auto_train || tx_line_signal !== LTA_LSIG_TRAINING)
		begin
			wait_cnt <= 8'h00;
			answered <= 1'b0;
		end
		else if (!answered && wait_cnt == train_delay)
		begin
			train_pulse <= 1'b1;
			answered <= 1'b1;
		end
		else if (!answered)
			wait_cnt <= wait_cnt + 8'h01;
	end

	assign ev = cmd | {6'h00, train_pulse, 4'h0};
endmodule // lta_far_end
`default_nettype wire

// ---- verif/lta_fsm_test.sv ----
/*
 * lta_fsm_test: self-checking bench for the line-side activation machine.
 * Assumes short budget counts; events are driven at the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module lta_fsm_test;
	import lta_pkg::*;
	localparam int NRM = 20;
	localparam int WST = 40;
	localparam int ACT = 0, DEA = 1, ROP = 2, RLS = 3, TRN = 4, SYN = 5;
	localparam int FLS = 6, RXL = 7, LAC = 8, LOP = 9, EXP = 10;
	logic sys_clk, rst, auto_train, function_element_stb, tx_frame_on;
	logic startup_late, startup_fail;
	logic [10:0] cmd, ev;
	logic [3:0] function_element, tx_line_signal, state_code;
	logic [3:0] merged_state;
	int failures = 0, comparisons = 0, cycles = 0;

	lta_far_end far_u (.sys_clk(sys_clk), .cmd(cmd), .auto_train(auto_train),
		.train_delay(8'h03), .tx_line_signal(tx_line_signal), .ev(ev));
	lta_fsm #(.NORMAL_CYCLES(LTA_TMR_W'(NRM)), .WORST_CYCLES(LTA_TMR_W'(WST)))
	dut_u (.sys_clk(sys_clk), .rst(rst), .ev_activate_req(ev[ACT]),
		.ev_deactivate_req(ev[DEA]), .ev_remote_op(ev[ROP]),
		.ev_remote_lost(ev[RLS]), .ev_remote_train(ev[TRN]),
		.ev_rx_synced(ev[SYN]), .ev_frame_loss(ev[FLS]), .ev_rx_loss(ev[RXL]),
		.ev_loop_activating(ev[LAC]), .ev_loop_operation(ev[LOP]),
		.ev_timer_expiry(ev[EXP]), .function_element(function_element),
		.function_element_stb(function_element_stb), .tx_frame_on(tx_frame_on),
		.tx_line_signal(tx_line_signal), .startup_late(startup_late),
		.startup_fail(startup_fail), .state_code(state_code));

	// second copy with received-signal loss merged into framing loss; it
	// must walk the same states as the first on the same events
	lta_fsm #(.NORMAL_CYCLES(LTA_TMR_W'(NRM)), .WORST_CYCLES(LTA_TMR_W'(WST)),
		.LOS_AS_FRAME_LOSS(1'b1))
	dut_m (.sys_clk(sys_clk), .rst(rst), .ev_activate_req(ev[ACT]),
		.ev_deactivate_req(ev[DEA]), .ev_remote_op(ev[ROP]),
		.ev_remote_lost(ev[RLS]), .ev_remote_train(ev[TRN]),
		.ev_rx_synced(ev[SYN]), .ev_frame_loss(ev[FLS]), .ev_rx_loss(ev[RXL]),
		.ev_loop_activating(ev[LAC]), .ev_loop_operation(ev[LOP]),
		.ev_timer_expiry(ev[EXP]), .function_element(),
		.function_element_stb(), .tx_frame_on(), .tx_line_signal(),
		.startup_late(), .startup_fail(), .state_code(merged_state));

	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [3:0] exp,
		input logic [3:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// pulse one event for a cycle; the next call or idle lowers it, so cmd
	// changes once per falling edge; strobe is judged in the answer cycle
	task automatic fire(input int idx, input logic stb_exp);
		cmd = 11'h001 << idx;
		@(negedge sys_clk);
		check("strobe", {3'h0, stb_exp}, {3'h0, function_element_stb});
	endtask

	task automatic look(input lta_state_t st, input logic [3:0] fe,
		input logic [3:0] tx);
		check("state", st, state_code);
		check("element", fe, function_element);
		check("line signal", tx, tx_line_signal);
		check("frame", {3'h0, st != LTA_DEACT}, {3'h0, tx_frame_on});
		check("merged state", st, merged_state);
	endtask

	task automatic flags(input logic late, input logic fail);
		check("late", {3'h0, late}, {3'h0, startup_late});
		check("fail", {3'h0, fail}, {3'h0, startup_fail});
	endtask

	task automatic idle(input int n);
		cmd = 11'h000;
		repeat (n) @(negedge sys_clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_pending;
		fire(ROP, 1'b1);
		check("pending b", LTA_PEND_B, state_code);
		fire(DEA, 1'b1);
		look(LTA_DEACT, LTA_FE_NONE, LTA_LSIG_NONE);
		fire(ACT, 1'b0);
		fire(ROP, 1'b1);
		check("pending a", LTA_PEND_A, state_code);
		fire(ACT, 1'b1);
		look(LTA_INITIATED, LTA_FE_INITIATED, LTA_LSIG_TRAINING);
	endtask

	// the timer restarted on entering initiated and runs there
	task automatic t_budget;
		idle(NRM - 4);
		flags(1'b0, 1'b0);
		idle(10);
		flags(1'b1, 1'b0);
		idle(20);
		flags(1'b1, 1'b1);
	endtask

	task automatic t_bring_up;
		int i;
		fire(ROP, 1'b1);
		look(LTA_ACTIVATING, LTA_FE_ACTIVATING, LTA_LSIG_TRAINING);
		fire(ROP, 1'b0);
		check("ignored", LTA_ACTIVATING, state_code);
		cmd = 11'h000;
		auto_train = 1'b1;
		for (i = 0; i < 20 && state_code !== LTA_ACTIVATED; i++)
			@(negedge sys_clk);
		auto_train = 1'b0;
		look(LTA_ACTIVATED, LTA_FE_ACTIVATED, LTA_LSIG_LOOP_OPERATION);
	endtask

	task automatic t_loop;
		fire(LOP, 1'b1);
		look(LTA_LOOP_ACTIVE, LTA_FE_LOOP_ACTIVE, LTA_LSIG_LOOP_OPERATION);
		fire(LAC, 1'b1);
		look(LTA_LOOP_DEFECT, LTA_FE_LOOP_DEFECT, LTA_LSIG_LOOP_OPERATION);
		fire(TRN, 1'b0);
		fire(LAC, 1'b0);
		look(LTA_LOOP_DEFECT, LTA_FE_LOOP_DEFECT, LTA_LSIG_LOOP_OPERATION);
		fire(LOP, 1'b1);
		look(LTA_LOOP_ACTIVE, LTA_FE_LOOP_ACTIVE, LTA_LSIG_LOOP_OPERATION);
	endtask

	task automatic t_framing;
		fire(FLS, 1'b1);
		look(LTA_FRAME_LOSS, LTA_FE_FAULT, LTA_LSIG_TRAINING);
		idle(3);
		flags(1'b0, 1'b0);
		idle(NRM + 6);
		flags(1'b1, 1'b0);
		fire(EXP, 1'b0);
		idle(2);
		flags(1'b1, 1'b1);
		fire(SYN, 1'b1);
		look(LTA_ACTIVATED, LTA_FE_ACTIVATED, LTA_LSIG_LOOP_OPERATION);
		fire(LOP, 1'b1);
		fire(LAC, 1'b1);
		fire(RXL, 1'b1);
		look(LTA_FRAME_LOSS, LTA_FE_FAULT, LTA_LSIG_TRAINING);
		fire(TRN, 1'b1);
		look(LTA_ACTIVATED, LTA_FE_ACTIVATED, LTA_LSIG_LOOP_OPERATION);
	endtask

	task automatic t_malfunction;
		fire(RLS, 1'b1);
		look(LTA_MALFUNCTION, LTA_FE_FAULT, LTA_LSIG_TRAINING);
		fire(RLS, 1'b0);
		look(LTA_MALFUNCTION, LTA_FE_FAULT, LTA_LSIG_TRAINING);
		fire(ROP, 1'b1);
		look(LTA_ACTIVATING, LTA_FE_ACTIVATING, LTA_LSIG_TRAINING);
		fire(DEA, 1'b1);
		look(LTA_DEACT, LTA_FE_NONE, LTA_LSIG_NONE);
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	// about 110 cycles are needed; the ceiling leaves ample margin
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			tally_and_finish();
		end
	end

	initial
	begin
		rst = 1'b1;
		cmd = 11'h000;
		auto_train = 1'b0;
		idle(5);
		rst = 1'b0;
		@(negedge sys_clk);
		look(LTA_DEACT, LTA_FE_NONE, LTA_LSIG_NONE);
		flags(1'b0, 1'b0);
		t_pending();
		t_budget();
		t_bring_up();
		t_loop();
		t_framing();
		t_malfunction();
		tally_and_finish();
	end
endmodule // lta_fsm_test
`default_nettype wire
